// File: core/pgcs_pkg.sv
package pgcs_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [13:0] IDX_PKT_LEN = 14'h061A;
   localparam logic [13:0] IDX_IPG = 14'h061B;
   localparam logic [13:0] IDX_BYTE_TOT = 14'h061C;
   localparam logic [13:0] IDX_PKT_LO = 14'h061D;
   localparam logic [13:0] IDX_PKT_HI = 14'h061E;
   localparam logic [13:0] IDX_FLAGS = 14'h0620;
   localparam logic [13:0] IDX_CTRL = 14'h0630;
   localparam logic [13:0] IDX_IRQ_STAT = 14'h0631;
   localparam logic [13:0] IDX_IRQ_CLR = 14'h0632;
   localparam logic [13:0] IDX_IRQ_EN = 14'h0633;

   // ----------------------------------------------------------------
   // Reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [15:0] RST_PKT_LEN = 16'h05DC;
   localparam logic [7:0] RST_IPG = 8'h7D;
   localparam logic [15:0] RST_PKT_REQ = 16'h0001;
   localparam logic [15:0] MAX_BYTE = 16'hFFFF;
   localparam logic [31:0] MAX_PKT = 32'hFFFFFFFF;
   localparam logic [7:0] MAX_ERR = 8'hFF;
   localparam int FL_SNAP = 0;
   localparam int FL_CLEAR = 1;
   localparam int FL_LOCK = 8;
   localparam int FL_BYTE_OV = 9;
   localparam int FL_PKT_OV = 10;
   localparam int FL_BUSY = 11;
   localparam int FL_DONE = 12;
   localparam int CT_GEN_EN = 0;
   localparam int CT_PRBS = 1;
   localparam int CT_CONT = 2;
   localparam int CT_SEND = 3;
   localparam int IRQ_W = 4;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_BYTE_OV = 1;
   localparam int IRQ_PKT_OV = 2;
   localparam int IRQ_LOCK = 3;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      GEN_IDLE = 2'b00,
      GEN_PKT = 2'b01,
      GEN_GAP = 2'b10
   } pgcs_gen_state_t;

   typedef struct packed
   {
      logic byte_valid;
      logic pkt_end;
      logic [3:0] err_bits;
      logic lock;
   } pgcs_rx_t;

   typedef struct packed
   {
      logic byte_valid;
      logic first;
      logic last;
      logic in_gap;
   } pgcs_gen_t;

   // Adds to a counter; top bit flags overflow (wrap or reaching max in single mode)
   function automatic logic [32:0] pgcs_count(logic [31:0] v, logic [31:0] add,
                                              logic [31:0] maxv, logic cont);
      logic [32:0] s;
      logic [32:0] r;
      s = {1'b0, v} + {1'b0, add};
      r = s;
      if (s > {1'b0, maxv})
      begin
         if (cont)
            r = {1'b1, 32'(s - {1'b0, maxv} - 33'h000000001)};
         else
            r = {1'b1, maxv};
      end
      else if (!cont && s == {1'b0, maxv} && add != 32'h00000000)
         r = {1'b1, maxv};
      else
         r = {1'b0, s[31:0]};
      return r;
   endfunction

endpackage

// File: core/pgcs_top.sv
// How it works
// [RULE1] Packet length comes from a 16-bit register that resets to 0x5DC.
// [RULE2] An idle gap of the 8-bit gap field bytes follows every packet; reset 0x7D.
// [RULE3] 16-bit received-byte counter stops at 0xFFFF in single mode.
// [RULE4] 32-bit received-packet counter, read as two halves, stops at 0xFFFFFFFF in single.
// [RULE5] 8-bit errored-bit counter in flags bits 7..0, stops at 0xFF in single.
// [RULE6] Writing flags bit 0 freezes a snapshot of all counters for reading.
// [RULE7] Writing flags bit 1 snapshots, clears counters and both overflow flags.
// [RULE8] Packet-counter overflow flag in bit 10 holds until counters are cleared.
// [RULE9] Byte-counter overflow flag in bit 9 holds until the clear write.
// [RULE10] Done flag bit 12 reads 1 once all requested MAC packets are sent.
// [RULE11] Bit 11 shows whether the generator is active.
// [RULE12] Bit 8 shows whether the checker is locked on the byte stream.
// [RULE13] Continuous mode wraps counters; single mode stops counting at any maximum.
// [RULE14] The send request bit clears itself when done is set.
// [RULE15] Busy rises at start and falls after the last packet's trailing gap.
`timescale 1ns/10ps
module pgcs_top
   import pgcs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire pgcs_rx_t rx_in,
   output pgcs_gen_t gen_out,
   output logic irq
);

   typedef struct packed
   {
      logic [15:0] pkt_len;
      logic [7:0] ipg;
      logic gen_en;
      logic gen_prbs;
      logic cnt_cont;
      logic send_pkt;
      logic [15:0] pkt_req;
      logic [15:0] byte_cnt;
      logic [31:0] pkt_cnt;
      logic [7:0] err_cnt;
      logic [15:0] byte_snap;
      logic [31:0] pkt_snap;
      logic [7:0] err_snap;
      logic byte_ov;
      logic pkt_ov;
      logic done;
      pgcs_gen_state_t gst;
      logic [15:0] gcnt;
      logic [15:0] sent;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_en;
      logic lock_prev;
      logic [31:0] rdata;
      pgcs_gen_t gen;
   } pgcs_regs_t;

   pgcs_regs_t s_reg;
   pgcs_regs_t s_next;

   logic [13:0] idx;
   logic aligned;
   logic mapped;
   logic wr_en;
   logic setup;
   logic snap_req;
   logic clr_req;
   logic stop_cnt;
   logic [32:0] byte_res;
   logic [32:0] pkt_res;
   logic [32:0] err_res;
   logic [15:0] flags_rd;
   logic [15:0] len_eff;
   logic last_byte;
   logic last_gap;
   logic run_on;
   logic all_sent;
   logic [IRQ_W-1:0] irq_set;

   // ----------------------------------------------------------------
   // APB decode: read data is captured in the setup cycle, so every
   // access completes in its first access cycle
   // ----------------------------------------------------------------
   assign idx = paddr[15:2];
   assign aligned = (paddr[1:0] == 2'b00);
   assign setup = psel && !penable;
   assign wr_en = psel && penable && pwrite && mapped;
   assign pready = psel && penable;
   assign pslverr = psel && penable && !mapped;
   assign prdata = s_reg.rdata;
   assign gen_out = s_reg.gen;
   assign irq = |(s_reg.irq_stat & s_reg.irq_en);

   // Address map
   always_comb
   begin
      mapped = 1'b0;
      if (aligned)
      begin
         unique case (idx)
            IDX_PKT_LEN, IDX_IPG, IDX_BYTE_TOT, IDX_PKT_LO, IDX_PKT_HI, IDX_FLAGS,
            IDX_CTRL, IDX_IRQ_STAT, IDX_IRQ_CLR, IDX_IRQ_EN: mapped = 1'b1;
            default: mapped = 1'b0;
         endcase
      end
   end

   // Status bits of the flags register; bits 7..0 read the errored-bit snapshot
   always_comb
   begin
      flags_rd = 16'h0000;
      flags_rd[7:0] = s_reg.err_snap;                       // [RULE5]
      flags_rd[FL_LOCK] = rx_in.lock;                       // [RULE12]
      flags_rd[FL_BYTE_OV] = s_reg.byte_ov;                 // [RULE9]
      flags_rd[FL_PKT_OV] = s_reg.pkt_ov;                   // [RULE8]
      flags_rd[FL_BUSY] = (s_reg.gst != GEN_IDLE);          // [RULE11]
      flags_rd[FL_DONE] = s_reg.done;                       // [RULE10]
   end

   // ----------------------------------------------------------------
   // Checker counters
   // ----------------------------------------------------------------
   assign snap_req = wr_en && idx == IDX_FLAGS && (pwdata[FL_SNAP] || pwdata[FL_CLEAR]);
   assign clr_req = wr_en && idx == IDX_FLAGS && pwdata[FL_CLEAR];
   // Single mode halts all three counters as soon as any one is pinned
   assign stop_cnt = !s_reg.cnt_cont && (s_reg.byte_cnt == MAX_BYTE ||
                     s_reg.pkt_cnt == MAX_PKT || s_reg.err_cnt == MAX_ERR);   // [RULE13]
   assign byte_res = pgcs_count({16'h0000, s_reg.byte_cnt},
                                {31'h00000000, rx_in.byte_valid && !stop_cnt},
                                {16'h0000, MAX_BYTE}, s_reg.cnt_cont);       // [RULE3]
   assign pkt_res = pgcs_count(s_reg.pkt_cnt,
                               {31'h00000000, rx_in.pkt_end && !stop_cnt},
                               MAX_PKT, s_reg.cnt_cont);                     // [RULE4]
   assign err_res = pgcs_count({24'h000000, s_reg.err_cnt},
                               {28'h0000000, stop_cnt ? 4'h0 : rx_in.err_bits},
                               {24'h000000, MAX_ERR}, s_reg.cnt_cont);      // [RULE5]

   // ----------------------------------------------------------------
   // Generator sequencing helpers
   // ----------------------------------------------------------------
   // A zero length still emits one byte so a packet is never empty
   assign len_eff = (s_reg.pkt_len == 16'h0000) ? 16'h0001 : s_reg.pkt_len;  // [RULE1]
   assign last_byte = (s_reg.gcnt == 16'(len_eff - 16'h0001));
   assign last_gap = (s_reg.gcnt == 16'({8'h00, s_reg.ipg} - 16'h0001));     // [RULE2]
   assign all_sent = (s_reg.pkt_req != 16'h0000) &&
                     (16'(s_reg.sent + 16'h0001) == s_reg.pkt_req);
   assign run_on = s_reg.gen_en && (s_reg.gen_prbs || s_reg.send_pkt);

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb
   begin
      s_next = s_reg;
      irq_set = '0;
      s_next.lock_prev = rx_in.lock;
      s_next.gen = '0;

      // Read data captured in setup
      if (setup && !pwrite)
      begin
         s_next.rdata = 32'h00000000;
         if (aligned)
         begin
            unique case (idx)
               IDX_PKT_LEN: s_next.rdata = {16'h0000, s_reg.pkt_len};
               IDX_IPG: s_next.rdata = {24'h000000, s_reg.ipg};
               IDX_BYTE_TOT: s_next.rdata = {16'h0000, s_reg.byte_snap};      // [RULE6]
               IDX_PKT_LO: s_next.rdata = {16'h0000, s_reg.pkt_snap[15:0]};   // [RULE4]
               IDX_PKT_HI: s_next.rdata = {16'h0000, s_reg.pkt_snap[31:16]};
               IDX_FLAGS: s_next.rdata = {16'h0000, flags_rd};
               IDX_CTRL: s_next.rdata = {s_reg.pkt_req, 12'h000, s_reg.send_pkt,
                                         s_reg.cnt_cont, s_reg.gen_prbs, s_reg.gen_en};
               IDX_IRQ_STAT: s_next.rdata = {28'h0000000, s_reg.irq_stat};
               IDX_IRQ_EN: s_next.rdata = {28'h0000000, s_reg.irq_en};
               default: s_next.rdata = 32'h00000000;
            endcase
         end
      end

      // Counters: clear zeroes them, otherwise they follow the adders
      s_next.byte_cnt = clr_req ? 16'h0000 : byte_res[15:0];                   // [RULE7]
      s_next.pkt_cnt = clr_req ? 32'h00000000 : pkt_res[31:0];
      s_next.err_cnt = clr_req ? 8'h00 : err_res[7:0];
      if (snap_req)
      begin
         s_next.byte_snap = s_reg.byte_cnt;                                    // [RULE6]
         s_next.pkt_snap = s_reg.pkt_cnt;
         s_next.err_snap = s_reg.err_cnt;
      end
      // Overflow flags: an overflow in the clear cycle still wins
      if (clr_req)
      begin
         s_next.byte_ov = 1'b0;                                                // [RULE7]
         s_next.pkt_ov = 1'b0;
      end
      if (byte_res[32] && !clr_req)
         s_next.byte_ov = 1'b1;                                                // [RULE9]
      if (pkt_res[32] && !clr_req)
         s_next.pkt_ov = 1'b1;                                                 // [RULE8]
      if (byte_res[32])
         irq_set[IRQ_BYTE_OV] = 1'b1;
      if (pkt_res[32])
         irq_set[IRQ_PKT_OV] = 1'b1;
      if (byte_res[32] && clr_req)
         s_next.byte_ov = 1'b1;
      if (pkt_res[32] && clr_req)
         s_next.pkt_ov = 1'b1;
      if (rx_in.lock && !s_reg.lock_prev)
         irq_set[IRQ_LOCK] = 1'b1;

      // Register writes
      if (wr_en)
      begin
         unique case (idx)
            IDX_PKT_LEN: s_next.pkt_len = pwdata[15:0];                       // [RULE1]
            IDX_IPG: s_next.ipg = pwdata[7:0];                                 // [RULE2]
            IDX_CTRL:
            begin
               s_next.gen_en = pwdata[CT_GEN_EN];
               s_next.gen_prbs = pwdata[CT_PRBS];
               s_next.cnt_cont = pwdata[CT_CONT];                              // [RULE13]
               s_next.send_pkt = pwdata[CT_SEND];
               s_next.pkt_req = pwdata[31:16];
               // A fresh send request starts a new run, so done drops
               if (pwdata[CT_SEND])
                  s_next.done = 1'b0;                                          // [RULE10]
            end
            IDX_IRQ_CLR: s_next.irq_stat = s_reg.irq_stat & ~pwdata[IRQ_W-1:0];
            IDX_IRQ_EN: s_next.irq_en = pwdata[IRQ_W-1:0];
            default: ;
         endcase
      end

      // Generator state machine
      unique case (s_reg.gst)
         GEN_IDLE:
         begin
            if (run_on)
            begin
               s_next.gst = GEN_PKT;                                           // [RULE15]
               s_next.gcnt = 16'h0000;
               s_next.sent = 16'h0000;
            end
         end
         GEN_PKT:
         begin
            s_next.gen.byte_valid = 1'b1;
            s_next.gen.first = (s_reg.gcnt == 16'h0000);
            s_next.gen.last = last_byte;
            s_next.gcnt = 16'(s_reg.gcnt + 16'h0001);
            if (last_byte)
            begin
               s_next.gcnt = 16'h0000;
               s_next.gst = GEN_GAP;                                           // [RULE2]
            end
         end
         GEN_GAP:
         begin
            s_next.gen.in_gap = (s_reg.ipg != 8'h00);
            s_next.gcnt = 16'(s_reg.gcnt + 16'h0001);
            // Busy stays up until the trailing gap of the last packet is out
            if (s_reg.ipg == 8'h00 || last_gap)
            begin
               s_next.gcnt = 16'h0000;
               s_next.sent = 16'(s_reg.sent + 16'h0001);
               if (!s_reg.gen_prbs && s_reg.send_pkt && all_sent)
               begin
                  s_next.done = 1'b1;                                          // [RULE10]
                  s_next.send_pkt = 1'b0;                                      // [RULE14]
                  irq_set[IRQ_DONE] = 1'b1;
                  s_next.gst = GEN_IDLE;                                       // [RULE15]
               end
               else if (run_on)
                  s_next.gst = GEN_PKT;
               else
                  s_next.gst = GEN_IDLE;
            end
         end
         default: s_next.gst = GEN_IDLE;
      endcase

      // Sticky interrupt bits: a new event beats a clear in the same cycle
      s_next.irq_stat = s_next.irq_stat | irq_set;
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         s_reg <= '0;
         s_reg.pkt_len <= RST_PKT_LEN;                                         // [RULE1]
         s_reg.ipg <= RST_IPG;                                                 // [RULE2]
         s_reg.pkt_req <= RST_PKT_REQ;
         s_reg.gst <= GEN_IDLE;
      end
      else
         s_reg <= s_next;
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence clear_write;
      psel && penable && pwrite && paddr[15:2] == IDX_FLAGS && paddr[1:0] == 2'b00
         && pwdata[FL_CLEAR];
   endsequence

   sequence gap_done_final;
      s_reg.gst == GEN_GAP && !s_reg.gen_prbs && s_reg.send_pkt && all_sent
         && (s_reg.ipg == 8'h00 || last_gap);
   endsequence

   AST_LEN_RESET: assert property (@(posedge sys_clk) $fell(srst) |->  // [RULE1]
      s_reg.pkt_len == RST_PKT_LEN && s_reg.ipg == RST_IPG)
      else $error("length or gap reset value wrong");

   AST_PKT_SPAN: assert property (@(posedge sys_clk) disable iff (srst)  // [RULE1]
      s_reg.gst == GEN_IDLE ##1 s_reg.gst == GEN_PKT && len_eff == 16'h0003
      && !(wr_en && idx == IDX_PKT_LEN) |-> ##2 s_reg.gst == GEN_PKT ##1 s_reg.gst == GEN_GAP)
      else $error("packet did not last its programmed length");

   AST_BYTE_SAT: assert property (@(posedge sys_clk) disable iff (srst)  // [RULE3]
      !s_reg.cnt_cont && s_reg.byte_cnt == MAX_BYTE && !clr_req |=> s_reg.byte_cnt == MAX_BYTE)
      else $error("byte counter moved past its maximum in single mode");

   AST_PKT_SAT: assert property (@(posedge sys_clk) disable iff (srst)  // [RULE4]
      !s_reg.cnt_cont && s_reg.pkt_cnt == MAX_PKT && !clr_req |=> s_reg.pkt_cnt == MAX_PKT)
      else $error("packet counter moved past its maximum in single mode");

   AST_ERR_SAT: assert property (@(posedge sys_clk) disable iff (srst)  // [RULE5]
      !s_reg.cnt_cont && s_reg.err_cnt == MAX_ERR && !clr_req |=> s_reg.err_cnt == MAX_ERR)
      else $error("error counter moved past its maximum in single mode");

   AST_SNAP_HOLD: assert property (@(posedge sys_clk) disable iff (srst)  // [RULE6]
      !snap_req |=> $stable(s_reg.byte_snap) && $stable(s_reg.pkt_snap))
      else $error("snapshot changed without a snapshot write");

   AST_CLEAR: assert property (@(posedge sys_clk) disable iff (srst)  // [RULE7]
      clear_write |=> s_reg.byte_cnt == 16'h0000 && s_reg.err_cnt == 8'h00
      && s_reg.byte_snap == $past(s_reg.byte_cnt))
      else $error("clear write did not snapshot and clear");

   AST_OV_STICKY: assert property (@(posedge sys_clk) disable iff (srst)  // [RULE8]
      s_reg.pkt_ov && !clr_req |=> s_reg.pkt_ov)
      else $error("packet overflow flag dropped without a clear");

   AST_BYTE_WRAP: assert property (@(posedge sys_clk) disable iff (srst)  // [RULE9]
      s_reg.cnt_cont && s_reg.byte_cnt == MAX_BYTE && rx_in.byte_valid && !clr_req
      |=> s_reg.byte_cnt == 16'h0000 && s_reg.byte_ov)
      else $error("byte wrap did not raise overflow");

   // The final gap end must always land in done with the request dropped, even if a
   // control write hits the same cycle
   AST_DONE_SEND: assert property (@(posedge sys_clk) disable iff (srst)  // [RULE14]
      gap_done_final |=> s_reg.done && !s_reg.send_pkt && s_reg.gst == GEN_IDLE
      && !flags_rd[FL_BUSY])
      else $error("done set without clearing send request");

   AST_BUSY: assert property (@(posedge sys_clk) disable iff (srst)  // [RULE11]
      s_reg.gst == GEN_IDLE && run_on |=> flags_rd[FL_BUSY] ##1 flags_rd[FL_BUSY])
      else $error("busy did not rise at start");

   // Watches the read path, so a wrong bit position in the captured word is caught
   AST_LOCK: assert property (@(posedge sys_clk) disable iff (srst)  // [RULE12]
      setup && !pwrite && aligned && idx == IDX_FLAGS
      |=> s_reg.rdata[FL_LOCK] == $past(rx_in.lock))
      else $error("lock bit does not follow checker");

endmodule

// File: tb/pgcs_top_bench.sv
`timescale 1ns/10ps
module pgcs_top_bench;
   import pgcs_pkg::*;

   // ----------------------------------------------------------------
   // Signals and instance
   // ----------------------------------------------------------------
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   pgcs_rx_t rx_in = '0;
   pgcs_gen_t gen_out;
   logic [31:0] rd_data;
   logic rd_err;
   int n_errors = 0;
   int n_checks = 0;
   int n_gbytes = 0;
   int n_ggap = 0;
   int n_gfirst = 0;
   int n_glast = 0;

   pgcs_top u_pgcs_top (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_in(rx_in), .gen_out(gen_out), .irq(irq));

   // 40 MHz clock
   always #12.5 sys_clk = ~sys_clk;

   // Generator output tally, guarded so unknowns never count
   always @(posedge sys_clk)
   begin
      if (gen_out.byte_valid === 1'b1) n_gbytes++;
      if (gen_out.in_gap === 1'b1) n_ggap++;
      if (gen_out.first === 1'b1) n_gfirst++;
      if (gen_out.last === 1'b1) n_glast++;
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task end_sim;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One APB transfer; request held until pready is sampled high
   task apb(input logic is_wr, input logic [13:0] idx, input logic [31:0] wd);
      int k;
      k = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= is_wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20)
      begin
         n_errors++;
         end_sim;
      end
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [13:0] idx, input logic [31:0] wd);
      apb(1'b1, idx, wd);
   endtask

   task rd(input string name, input logic [13:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h00000000);
      check(name, rd_data, exp);
   endtask

   // Received stream: n byte cycles with the given error bits and packet end
   task rx_run(input int n, input logic [3:0] e, input logic pe);
      repeat (n)
      begin
         @(posedge sys_clk);
         rx_in.byte_valid <= 1'b1;
         rx_in.err_bits <= e;
         rx_in.pkt_end <= pe;
      end
      @(posedge sys_clk);
      rx_in.byte_valid <= 1'b0;
      rx_in.err_bits <= 4'h0;
      rx_in.pkt_end <= 1'b0;
   endtask

   // Hang guard: a stuck run still ends through the closing report
   initial
   begin
      repeat (95000) @(posedge sys_clk);
      n_errors++;
      end_sim;
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      int k;
      repeat (10) @(posedge sys_clk);
      srst <= 1'b0;
      rd("pkt_len_rst", IDX_PKT_LEN, 32'h000005DC);
      rd("ipg_rst", IDX_IPG, 32'h0000007D);
      rd("flags_rst", IDX_FLAGS, 32'h00000000);
      rd("ctrl_rst", IDX_CTRL, 32'h00010000);
      rd("irq_en_rst", IDX_IRQ_EN, 32'h00000000);
      apb(1'b0, 14'h0621, 32'h00000000);
      check("unmapped_err", {31'h00000000, rd_err}, 32'h00000001);
      check("unmapped_data", rd_data, 32'h00000000);
      wr(IDX_IPG, 32'h0000FFFF);
      rd("ipg_field", IDX_IPG, 32'h000000FF);
      wr(IDX_BYTE_TOT, 32'h0000FFFF);
      rd("byte_ro", IDX_BYTE_TOT, 32'h00000000);
      // Continuous mode: error count wraps, 300 errors leave 0x2C
      rx_in.lock <= 1'b1;
      wr(IDX_CTRL, 32'h00010004);
      rx_run(20, 4'hF, 1'b0);
      rx_run(2, 4'h0, 1'b1);
      wr(IDX_FLAGS, 32'h00000001);
      rd("byte_snap", IDX_BYTE_TOT, 32'h00000016);
      rd("pkt_lo", IDX_PKT_LO, 32'h00000002);
      rd("pkt_hi", IDX_PKT_HI, 32'h00000000);
      rd("flags_wrap", IDX_FLAGS, 32'h0000012C);
      rx_run(5, 4'h1, 1'b1);
      rd("byte_frozen", IDX_BYTE_TOT, 32'h00000016);
      rd("pkt_frozen", IDX_PKT_LO, 32'h00000002);
      wr(IDX_FLAGS, 32'h00000002);
      wr(IDX_FLAGS, 32'h00000001);
      rd("byte_clr", IDX_BYTE_TOT, 32'h00000000);
      rd("pkt_clr", IDX_PKT_LO, 32'h00000000);
      rd("flags_clr", IDX_FLAGS, 32'h00000100);
      // Single mode: error count stops at its maximum
      wr(IDX_CTRL, 32'h00010000);
      rx_run(20, 4'hF, 1'b0);
      wr(IDX_FLAGS, 32'h00000001);
      rd("err_sat", IDX_FLAGS, 32'h000001FF);
      wr(IDX_FLAGS, 32'h00000002);
      // Single mode byte total reaches 0xFFFF and holds; the long run is unavoidable
      rx_run(65538, 4'h0, 1'b0);
      wr(IDX_FLAGS, 32'h00000001);
      rd("byte_sat", IDX_BYTE_TOT, 32'h0000FFFF);
      rd("byte_ov", IDX_FLAGS, 32'h00000300);
      rd("irq_stat", IDX_IRQ_STAT, 32'h0000000A);
      check("irq_masked", {31'h00000000, irq}, 32'h00000000);
      wr(IDX_IRQ_CLR, 32'h0000000F);
      rd("irq_stat_clr", IDX_IRQ_STAT, 32'h00000000);
      wr(IDX_FLAGS, 32'h00000002);
      rd("ov_clr", IDX_FLAGS, 32'h00000100);
      // Generator: two MAC packets of 3 bytes, gap 2
      wr(IDX_PKT_LEN, 32'h00000003);
      wr(IDX_IPG, 32'h00000002);
      wr(IDX_IRQ_EN, 32'h00000001);
      n_gbytes = 0;
      n_ggap = 0;
      wr(IDX_CTRL, 32'h0002000D);
      repeat (2) @(posedge sys_clk);
      apb(1'b0, IDX_FLAGS, 32'h00000000);
      check("gen_busy", {30'h00000000, rd_data[12:11]}, 32'h00000001);
      k = 0;
      do
      begin
         apb(1'b0, IDX_FLAGS, 32'h00000000);
         k++;
      end while (rd_data[12] !== 1'b1 && k < 30);
      // A generator that never finishes must not run on past its bound
      if (k >= 30 && rd_data[12] !== 1'b1)
      begin
         n_errors++;
         end_sim;
      end
      check("gen_done", {30'h00000000, rd_data[12:11]}, 32'h00000002);
      rd("send_self_clr", IDX_CTRL, 32'h00020005);
      check("gen_bytes", n_gbytes, 32'h00000006);
      check("gen_gap", n_ggap, 32'h00000004);
      check("gen_first", n_gfirst, 32'h00000002);
      check("gen_last", n_glast, 32'h00000002);
      check("irq_done", {31'h00000000, irq}, 32'h00000001);
      wr(IDX_IRQ_CLR, 32'h00000001);
      @(posedge sys_clk);
      check("irq_clr", {31'h00000000, irq}, 32'h00000000);
      end_sim;
   end
endmodule
